/* logic/sbcp_cfg.svh */
// Offsets, field positions and reset values of the configuration port
`ifndef SBCP_CFG_SVH
`define SBCP_CFG_SVH
`define SBCP_ADDR_STRAP0  7'h68
`define SBCP_ADDR_STRAP1  7'h6a
`define SBCP_IDX_OE       8'h00
`define SBCP_IDX_SPREAD   8'h01
`define SBCP_IDX_RSVD     8'h04
`define SBCP_IDX_COUNT    8'h07
`define SBCP_IDX_STEP     8'h01
`define SBCP_OE_RESET     4'hf
`define SBCP_OVR_RESET    1'b0
`define SBCP_SW_RESET     2'h0
`define SBCP_AMP_RESET    2'h2
`define SBCP_COUNT_RESET  5'h08
`define SBCP_SPREAD_RESET 2'h0
`define SBCP_RSVD_BYTE    8'hff
`define SBCP_B1_RSVD_BIT  1'b1
`define SBCP_OE_HI        3
`define SBCP_OVR_BIT      5
`define SBCP_SW_HI        4
`define SBCP_SW_LO        3
`define SBCP_AMP_HI       1
`define SBCP_CNT_HI       4
`define SBCP_BYTE_BITS    4'h8
`define SBCP_BIT_FIRST    4'h1
`endif

/* logic/sbcp_pkg.sv */
// Types shared by the configuration port
package sbcp_pkg;
   typedef enum logic [3:0] {
      S_IDLE      = 4'b0000,
      S_ADDR      = 4'b0001,
      S_ADDR_ACK  = 4'b0010,
      S_INDEX     = 4'b0011,
      S_INDEX_ACK = 4'b0100,
      S_COUNT     = 4'b0101,
      S_COUNT_ACK = 4'b0110,
      S_WDATA     = 4'b0111,
      S_WDATA_ACK = 4'b1000,
      S_TX        = 4'b1001,
      S_TX_ACK    = 4'b1010
   } sbcp_state_type;

   typedef struct packed {
      logic [3:0] oe;
      logic [1:0] spread;
      logic [1:0] amp;
   } sbcp_out_type;
endpackage

/* logic/sbcp_port.sv */
// Serial management slave port with indexed block transfers and config registers
`timescale 1ns/10ps
`include "sbcp_cfg.svh"

module sbcp_port (
   input  wire logic       CLK,
   input  wire logic       RESET,
   input  wire logic       LINK_CLK,
   input  wire logic       SCL_IN,
   input  wire logic       SDA_IN,
   output logic            SDA_OUT,
   output logic            SDA_OE,
   input  wire logic       ADDRESS_SELECT_STRAP,
   input  wire logic [1:0] SPREAD_STRAP_LEVEL,
   output logic [3:0]      DIFF_OUTPUT_ENABLE,
   output logic [1:0]      SPREAD_SELECT,
   output logic [1:0]      AMPLITUDE_SELECT
);

   // Link domain reset and pin synchronisers
   logic       rst_meta_reg;
   logic       rst_link;
   logic [2:0] scl_s_reg;
   logic [2:0] sda_s_reg;
   logic       scl_f_reg;
   logic       sda_f_reg;
   logic       scl_d_reg;
   logic       sda_d_reg;
   logic [2:0] strap_s0_reg;
   logic [2:0] strap_s1_reg;
   logic [2:0] strap_s2_reg;
   logic       strap_pend_reg;
   logic       addr_sel_reg;
   logic [1:0] strap_rb_reg;

   // Reset level carried into the link clock domain
   always_ff @(posedge LINK_CLK) begin
      rst_meta_reg <= RESET;
      rst_link     <= rst_meta_reg;
   end

   // Three stages; a level counts once the second and third agree
   always_ff @(posedge LINK_CLK) begin
      scl_s_reg    <= {scl_s_reg[1:0], SCL_IN};
      sda_s_reg    <= {sda_s_reg[1:0], SDA_IN};
      strap_s0_reg <= {SPREAD_STRAP_LEVEL, ADDRESS_SELECT_STRAP};
      strap_s1_reg <= strap_s0_reg;
      strap_s2_reg <= strap_s1_reg;
   end

   // Filtered bus levels and their previous values
   always_ff @(posedge LINK_CLK) begin
      if (rst_link) begin
         scl_f_reg <= 1'b1;
         sda_f_reg <= 1'b1;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         if (scl_s_reg[1] == scl_s_reg[2]) scl_f_reg <= scl_s_reg[2];
         if (sda_s_reg[1] == sda_s_reg[2]) sda_f_reg <= sda_s_reg[2];
         scl_d_reg <= scl_f_reg;
         sda_d_reg <= sda_f_reg;
      end
   end

   // Straps caught once after reset release, then held
   always_ff @(posedge LINK_CLK) begin
      if (rst_link) begin
         strap_pend_reg <= 1'b1;
         addr_sel_reg   <= 1'b0;
         strap_rb_reg   <= `SBCP_SPREAD_RESET;
      end else if (strap_pend_reg && strap_s1_reg == strap_s2_reg) begin
         strap_pend_reg <= 1'b0;
         addr_sel_reg   <= strap_s2_reg[0];
         strap_rb_reg   <= strap_s2_reg[2:1];
      end
   end

   // Bus events: start and stop while the clock is high
   wire       scl_rise  = scl_f_reg & ~scl_d_reg;
   wire       scl_fall  = ~scl_f_reg & scl_d_reg;
   wire       bus_start = scl_f_reg & scl_d_reg & sda_d_reg & ~sda_f_reg;
   wire       bus_stop  = scl_f_reg & scl_d_reg & ~sda_d_reg & sda_f_reg;
   wire [6:0] own_addr  = addr_sel_reg ? `SBCP_ADDR_STRAP1 : `SBCP_ADDR_STRAP0;

   // Protocol state
   sbcp_pkg::sbcp_state_type state_reg;
   sbcp_pkg::sbcp_state_type state_next;
   logic [3:0] bit_reg;
   logic [3:0] bit_next;
   logic [7:0] shift_reg;
   logic [7:0] shift_next;
   logic [7:0] tx_reg;
   logic [7:0] tx_next;
   logic [7:0] idx_reg;
   logic [7:0] idx_next;
   logic [7:0] left_reg;
   logic [7:0] left_next;
   logic       rw_reg;
   logic       rw_next;
   logic       hack_reg;
   logic       hack_next;
   logic       drive_reg;
   logic       drive_next;
   logic       wr_en;

   // Configuration registers
   logic [3:0] oe_reg;
   logic       ovr_reg;
   logic [1:0] sw_reg;
   logic [1:0] amp_reg;
   logic [4:0] count_reg;

   // Decodes for the byte in flight
   wire       byte_done  = (bit_reg == `SBCP_BYTE_BITS);
   wire       addr_match = !strap_pend_reg && (shift_reg[7:1] == own_addr);
   wire [7:0] idx_inc    = idx_reg + `SBCP_IDX_STEP;
   wire [7:0] count_byte = {3'h0, count_reg};

   // Read data selection; unmapped indices read zero
   wire [7:0] rd_byte =
      (idx_reg == `SBCP_IDX_OE)     ? {4'h0, oe_reg} :
      (idx_reg == `SBCP_IDX_SPREAD) ? {strap_rb_reg, ovr_reg, sw_reg,
                                       `SBCP_B1_RSVD_BIT, amp_reg} :
      (idx_reg == `SBCP_IDX_RSVD)   ? `SBCP_RSVD_BYTE :
      (idx_reg == `SBCP_IDX_COUNT)  ? count_byte : 8'h00;

   // Next-state logic of the slave; start and stop override every state
   always_comb begin
      state_next = state_reg;
      bit_next   = bit_reg;
      shift_next = shift_reg;
      tx_next    = tx_reg;
      idx_next   = idx_reg;
      left_next  = left_reg;
      rw_next    = rw_reg;
      hack_next  = hack_reg;
      drive_next = drive_reg;
      wr_en      = 1'b0;
      if (bus_start) begin
         // Repeated start lands here too, keeping the index
         state_next = sbcp_pkg::S_ADDR;
         bit_next   = 4'h0;
         drive_next = 1'b0;
      end else if (bus_stop) begin
         state_next = sbcp_pkg::S_IDLE;
         drive_next = 1'b0;
      end else begin
         case (state_reg)
            sbcp_pkg::S_ADDR, sbcp_pkg::S_INDEX, sbcp_pkg::S_COUNT, sbcp_pkg::S_WDATA: begin
               if (scl_rise && !byte_done) begin
                  shift_next = {shift_reg[6:0], sda_f_reg};
                  bit_next   = bit_reg + `SBCP_BIT_FIRST;
               end else if (scl_fall && byte_done) begin
                  bit_next = 4'h0;
                  if (state_reg == sbcp_pkg::S_ADDR) begin
                     if (addr_match) begin
                        drive_next = 1'b1;
                        rw_next    = shift_reg[0];
                        state_next = sbcp_pkg::S_ADDR_ACK;
                     end else begin
                        state_next = sbcp_pkg::S_IDLE;
                     end
                  end else if (state_reg == sbcp_pkg::S_INDEX) begin
                     idx_next   = shift_reg;
                     drive_next = 1'b1;
                     state_next = sbcp_pkg::S_INDEX_ACK;
                  end else if (state_reg == sbcp_pkg::S_COUNT) begin
                     left_next  = shift_reg;
                     drive_next = 1'b1;
                     state_next = sbcp_pkg::S_COUNT_ACK;
                  end else if (left_reg != 8'h00) begin
                     wr_en      = 1'b1;
                     idx_next   = idx_inc;
                     left_next  = left_reg - 8'h01;
                     drive_next = 1'b1;
                     state_next = sbcp_pkg::S_WDATA_ACK;
                  end else begin
                     // Bytes past the count are refused
                     state_next = sbcp_pkg::S_IDLE;
                  end
               end
            end
            sbcp_pkg::S_ADDR_ACK: begin
               if (scl_fall && rw_reg) begin
                  tx_next    = count_byte;
                  drive_next = ~count_byte[7];
                  bit_next   = `SBCP_BIT_FIRST;
                  state_next = sbcp_pkg::S_TX;
               end else if (scl_fall) begin
                  drive_next = 1'b0;
                  state_next = sbcp_pkg::S_INDEX;
               end
            end
            sbcp_pkg::S_INDEX_ACK: begin
               if (scl_fall) begin
                  drive_next = 1'b0;
                  state_next = sbcp_pkg::S_COUNT;
               end
            end
            sbcp_pkg::S_COUNT_ACK, sbcp_pkg::S_WDATA_ACK: begin
               if (scl_fall) begin
                  drive_next = 1'b0;
                  state_next = sbcp_pkg::S_WDATA;
               end
            end
            sbcp_pkg::S_TX: begin
               if (scl_fall && byte_done) begin
                  drive_next = 1'b0;
                  state_next = sbcp_pkg::S_TX_ACK;
               end else if (scl_fall) begin
                  tx_next    = {tx_reg[6:0], 1'b0};
                  drive_next = ~tx_reg[6];
                  bit_next   = bit_reg + `SBCP_BIT_FIRST;
               end
            end
            sbcp_pkg::S_TX_ACK: begin
               if (scl_rise) begin
                  hack_next = ~sda_f_reg;
               end else if (scl_fall && hack_reg) begin
                  tx_next    = rd_byte;
                  drive_next = ~rd_byte[7];
                  idx_next   = idx_inc;
                  bit_next   = `SBCP_BIT_FIRST;
                  state_next = sbcp_pkg::S_TX;
               end else if (scl_fall) begin
                  state_next = sbcp_pkg::S_IDLE;
               end
            end
            default: begin
               state_next = sbcp_pkg::S_IDLE;
               drive_next = 1'b0;
            end
         endcase
      end
   end

   // Protocol registers
   always_ff @(posedge LINK_CLK) begin
      if (rst_link) begin
         state_reg <= sbcp_pkg::S_IDLE;
         bit_reg   <= 4'h0;
         shift_reg <= 8'h00;
         tx_reg    <= 8'h00;
         idx_reg   <= 8'h00;
         left_reg  <= 8'h00;
         rw_reg    <= 1'b0;
         hack_reg  <= 1'b0;
         drive_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         bit_reg   <= bit_next;
         shift_reg <= shift_next;
         tx_reg    <= tx_next;
         idx_reg   <= idx_next;
         left_reg  <= left_next;
         rw_reg    <= rw_next;
         hack_reg  <= hack_next;
         drive_reg <= drive_next;
      end
   end

   // Register writes; read-only and reserved bits take nothing
   always_ff @(posedge LINK_CLK) begin
      if (rst_link) begin
         oe_reg    <= `SBCP_OE_RESET;
         ovr_reg   <= `SBCP_OVR_RESET;
         sw_reg    <= `SBCP_SW_RESET;
         amp_reg   <= `SBCP_AMP_RESET;
         count_reg <= `SBCP_COUNT_RESET;
      end else if (wr_en) begin
         if (idx_reg == `SBCP_IDX_OE) oe_reg <= shift_reg[`SBCP_OE_HI:0];
         if (idx_reg == `SBCP_IDX_SPREAD) begin
            ovr_reg <= shift_reg[`SBCP_OVR_BIT];
            sw_reg  <= shift_reg[`SBCP_SW_HI:`SBCP_SW_LO];
            amp_reg <= shift_reg[`SBCP_AMP_HI:0];
         end
         if (idx_reg == `SBCP_IDX_COUNT) count_reg <= shift_reg[`SBCP_CNT_HI:0];
      end
   end

   // Effective settings; software field only counts under override
   sbcp_pkg::sbcp_out_type live_word;
   wire [1:0] spread_eff = ovr_reg ? sw_reg : strap_rb_reg;
   assign live_word = '{oe: oe_reg, spread: spread_eff, amp: amp_reg};

   // Word crossing by toggle handshake; word held until acknowledged
   sbcp_pkg::sbcp_out_type xw_reg;
   sbcp_pkg::sbcp_out_type out_reg;
   logic       xtog_reg;
   logic [2:0] ack_s_reg;
   logic       ack_f_reg;
   logic [2:0] tog_s_reg;
   logic       tog_f_reg;
   logic       seen_reg;
   wire        x_pending = (xtog_reg != ack_f_reg);

   // Link side of the crossing
   always_ff @(posedge LINK_CLK) begin
      ack_s_reg <= {ack_s_reg[1:0], seen_reg};
      if (rst_link) begin
         xw_reg    <= '{oe: `SBCP_OE_RESET, spread: `SBCP_SPREAD_RESET, amp: `SBCP_AMP_RESET};
         xtog_reg  <= 1'b0;
         ack_f_reg <= 1'b0;
      end else begin
         if (ack_s_reg[1] == ack_s_reg[2]) ack_f_reg <= ack_s_reg[2];
         if (!x_pending && live_word != xw_reg) begin
            xw_reg   <= live_word;
            xtog_reg <= ~xtog_reg;
         end
      end
   end

   // Core side: take the word once the toggle has settled
   always_ff @(posedge CLK) begin
      tog_s_reg <= {tog_s_reg[1:0], xtog_reg};
      if (RESET) begin
         tog_f_reg <= 1'b0;
         seen_reg  <= 1'b0;
         out_reg   <= '{oe: `SBCP_OE_RESET, spread: `SBCP_SPREAD_RESET, amp: `SBCP_AMP_RESET};
      end else begin
         if (tog_s_reg[1] == tog_s_reg[2]) tog_f_reg <= tog_s_reg[2];
         if (tog_f_reg != seen_reg) begin
            out_reg  <= xw_reg;
            seen_reg <= tog_f_reg;
         end
      end
   end

   // Pin and output drive; open drain only ever pulls low
   assign SDA_OUT            = 1'b0;
   assign SDA_OE             = drive_reg;
   assign DIFF_OUTPUT_ENABLE = out_reg.oe;
   assign SPREAD_SELECT      = out_reg.spread;
   assign AMPLITUDE_SELECT   = out_reg.amp;

   // Checks on the link side
   sequence seq_byte_end(sbcp_pkg::sbcp_state_type st);
      state_reg == st && byte_done && scl_fall && !bus_start && !bus_stop;
   endsequence
   sequence seq_wr_byte;
      seq_byte_end(sbcp_pkg::S_WDATA) ##0 (left_reg != 8'h00);
   endsequence

   a_addr_ack: assert property (@(posedge LINK_CLK) disable iff (rst_link)
      seq_byte_end(sbcp_pkg::S_ADDR) ##0 addr_match |=> SDA_OE && state_reg == sbcp_pkg::S_ADDR_ACK)
      else $error("own address not acknowledged");
   a_index_ack: assert property (@(posedge LINK_CLK) disable iff (rst_link)
      seq_byte_end(sbcp_pkg::S_INDEX) |=> SDA_OE && idx_reg == $past(shift_reg))
      else $error("index byte not taken or acknowledged");
   a_count_ack: assert property (@(posedge LINK_CLK) disable iff (rst_link)
      seq_byte_end(sbcp_pkg::S_COUNT) |=> SDA_OE && left_reg == $past(shift_reg))
      else $error("count byte not taken or acknowledged");
   a_oe_store: assert property (@(posedge LINK_CLK) disable iff (rst_link)
      seq_wr_byte ##0 (idx_reg == `SBCP_IDX_OE) |=> oe_reg == $past(shift_reg[3:0]))
      else $error("output enable byte not stored");
   a_data_ack: assert property (@(posedge LINK_CLK) disable iff (rst_link)
      seq_wr_byte |=> SDA_OE ##1 SDA_OE [*1])
      else $error("data byte not acknowledged");
   a_count_first: assert property (@(posedge LINK_CLK) disable iff (rst_link)
      state_reg == sbcp_pkg::S_ADDR_ACK && scl_fall && rw_reg && !bus_start && !bus_stop
      |=> state_reg == sbcp_pkg::S_TX && tx_reg == {3'h0, $past(count_reg)})
      else $error("read did not open with the byte count");
   a_strap_held: assert property (@(posedge LINK_CLK) disable iff (rst_link)
      !strap_pend_reg && $past(!strap_pend_reg) |-> $stable(addr_sel_reg) && $stable(strap_rb_reg))
      else $error("strap level followed after capture");
   a_rsvd_ones: assert property (@(posedge LINK_CLK) disable iff (rst_link)
      state_reg == sbcp_pkg::S_TX_ACK && scl_fall && hack_reg && idx_reg == `SBCP_IDX_RSVD
      && !bus_start && !bus_stop |=> tx_reg == `SBCP_RSVD_BYTE)
      else $error("reserved index not all ones");
   a_sw_gate: assert property (@(posedge LINK_CLK) disable iff (rst_link)
      !ovr_reg && $changed(sw_reg) |-> live_word.spread == strap_rb_reg)
      else $error("software spread acted without override");
   a_idx_step: assert property (@(posedge LINK_CLK) disable iff (rst_link)
      seq_wr_byte |=> idx_reg == $past(idx_inc))
      else $error("index did not advance by one");

endmodule // sbcp_port

/* verification/sbcp_host.sv */
// Behavioural SMBus host controller driving the shared clock and data lines
`timescale 1ns/10ps

module sbcp_host #(
   parameter int QTR = 10
) (
   input  wire logic CLK,
   input  wire logic SDA_OE,
   input  wire logic SDA_OUT,
   output logic      SCL,
   output logic      SDA
);
   logic drv_sda;

   // Open-drain wire with pull-up; device pulls only when enabled and driving low
   assign SDA = drv_sda & ~(SDA_OE & ~SDA_OUT);

   initial begin
      SCL = 1'b1;
      drv_sda = 1'b1;
   end

   // Quarter bit; long enough to clear the three-stage input filter
   task automatic q(input int n);
      repeat (n * QTR) @(negedge CLK);
   endtask

   // Start, also serves as repeated start
   task automatic start();
      drv_sda = 1'b1;
      q(1);
      SCL = 1'b1;
      q(1);
      drv_sda = 1'b0;
      q(1);
      SCL = 1'b0;
      q(1);
   endtask

   // Stop, then bus free time
   task automatic stop();
      drv_sda = 1'b0;
      q(1);
      SCL = 1'b1;
      q(1);
      drv_sda = 1'b1;
      q(4);
   endtask

   // One bit; data changes only while the clock is low
   task automatic bit_io(input logic b, output logic seen);
      drv_sda = b;
      q(1);
      SCL = 1'b1;
      q(1);
      seen = SDA;
      q(1);
      SCL = 1'b0;
      q(1);
   endtask

   // Byte to device, MSB first; ack is a low wire in the ninth bit
   task automatic byte_out(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask

   // Byte from device, then host ack or not-acknowledge
   task automatic byte_in(output logic [7:0] d, input logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         d[i] = s;
      end
      bit_io(~ack, s);
   endtask
endmodule // sbcp_host

/* verification/tb_smbus_block_config_port.sv */
// Self-checking bench for the configuration port against a host model
`timescale 1ns/10ps
`include "sbcp_cfg.svh"

module tb_smbus_block_config_port;
   logic        CLK = 1'b0;
   logic        LINK_CLK = 1'b0;
   logic        RESET = 1'b1;
   logic        SCL, SDA, SDA_OE, SDA_OUT;
   logic        ADDRESS_SELECT_STRAP = 1'b0;
   logic [1:0]  SPREAD_STRAP_LEVEL = 2'b01;
   logic [3:0]  DIFF_OUTPUT_ENABLE;
   logic [1:0]  SPREAD_SELECT, AMPLITUDE_SELECT;
   int          err_count = 0;
   int          n_tests = 0;
   logic [31:0] lfsr = 32'h4e7c;
   logic [6:0]  addr = `SBCP_ADDR_STRAP0;
   logic [3:0]  oe_m;
   logic        ovr_m;
   logic [1:0]  sw_m, amp_m, rb_m;
   logic [4:0]  cnt_m;
   logic [7:0]  dq[$];

   // Core clock; link clock offset by 7 ns, yet edges of the two still align every 600 ns
   always #12.5 CLK = ~CLK;
   initial begin
      #7;
      forever #24 LINK_CLK = ~LINK_CLK;
   end

   sbcp_port u_sbcp_port (.CLK(CLK), .RESET(RESET), .LINK_CLK(LINK_CLK), .SCL_IN(SCL),
      .SDA_IN(SDA), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
      .ADDRESS_SELECT_STRAP(ADDRESS_SELECT_STRAP), .SPREAD_STRAP_LEVEL(SPREAD_STRAP_LEVEL),
      .DIFF_OUTPUT_ENABLE(DIFF_OUTPUT_ENABLE), .SPREAD_SELECT(SPREAD_SELECT),
      .AMPLITUDE_SELECT(AMPLITUDE_SELECT));
   sbcp_host u_sbcp_host (.CLK(CLK), .SDA_OE(SDA_OE), .SDA_OUT(SDA_OUT), .SCL(SCL), .SDA(SDA));

   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Expected read value from the shadow copy
   function automatic logic [7:0] exp_reg(input logic [7:0] idx);
      case (idx)
         `SBCP_IDX_OE:    return {4'h0, oe_m};
         `SBCP_IDX_SPREAD: return {rb_m, ovr_m, sw_m, 1'b1, amp_m};
         `SBCP_IDX_RSVD:  return 8'hff;
         `SBCP_IDX_COUNT: return {3'h0, cnt_m};
         default:         return 8'h00;
      endcase
   endfunction

   // Shadow update; read-only and reserved bits are dropped
   task automatic apply(input logic [7:0] idx, input logic [7:0] d);
      case (idx)
         `SBCP_IDX_OE:    oe_m = d[3:0];
         `SBCP_IDX_SPREAD: {ovr_m, sw_m, amp_m} = {d[5:3], d[1:0]};
         `SBCP_IDX_COUNT: cnt_m = d[4:0];
         default:         ;
      endcase
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Reset with new strap levels; the device captures them once
   task automatic do_reset(input logic s, input logic [1:0] sp);
      RESET = 1'b1;
      ADDRESS_SELECT_STRAP = s;
      SPREAD_STRAP_LEVEL = sp;
      repeat (8) @(negedge CLK);
      RESET = 1'b0;
      {oe_m, ovr_m, sw_m} = {`SBCP_OE_RESET, `SBCP_OVR_RESET, `SBCP_SW_RESET};
      {amp_m, cnt_m, rb_m} = {`SBCP_AMP_RESET, `SBCP_COUNT_RESET, sp};
      addr = s ? `SBCP_ADDR_STRAP1 : `SBCP_ADDR_STRAP0;
      repeat (60) @(negedge CLK);
   endtask

   // Pins follow registers after the crossing settles
   task automatic chk_pins();
      check({4'h0, DIFF_OUTPUT_ENABLE}, {4'h0, oe_m});
      check({6'h0, AMPLITUDE_SELECT}, {6'h0, amp_m});
      check({6'h0, SPREAD_SELECT}, {6'h0, ovr_m ? sw_m : rb_m});
   endtask

   task automatic probe(input logic [6:0] a7, input logic exp);
      logic a;
      u_sbcp_host.start();
      u_sbcp_host.byte_out({a7, 1'b0}, a);
      u_sbcp_host.stop();
      check({7'h0, a}, {7'h0, exp});
   endtask

   // Block write; bytes beyond the count must be refused
   task automatic wr_block(input logic [7:0] n, input logic [7:0] x, input logic [7:0] d[$]);
      logic a;
      u_sbcp_host.start();
      u_sbcp_host.byte_out({addr, 1'b0}, a);
      check({7'h0, a}, 8'h01);
      u_sbcp_host.byte_out(n, a);
      check({7'h0, a}, 8'h01);
      u_sbcp_host.byte_out(x, a);
      check({7'h0, a}, 8'h01);
      foreach (d[k]) begin
         u_sbcp_host.byte_out(d[k], a);
         check({7'h0, a}, {7'h0, k < x});
         if (k < x) apply(8'(n + k), d[k]);
      end
      u_sbcp_host.stop();
      repeat (60) @(negedge CLK);
   endtask

   // Block read of len bytes after the count byte
   task automatic rd_block(input logic [7:0] n, input int len);
      logic a;
      logic [7:0] v;
      u_sbcp_host.start();
      u_sbcp_host.byte_out({addr, 1'b0}, a);
      u_sbcp_host.byte_out(n, a);
      u_sbcp_host.start();
      u_sbcp_host.byte_out({addr, 1'b1}, a);
      check({7'h0, a}, 8'h01);
      u_sbcp_host.byte_in(v, 1'b1);
      check(v, {3'h0, cnt_m});
      for (int k = 0; k < len; k++) begin
         u_sbcp_host.byte_in(v, k < len - 1);
         check(v, exp_reg(8'(n + k)));
      end
      u_sbcp_host.stop();
   endtask

   // Main sequence
   initial begin
      logic [7:0] d1;
      do_reset(1'b0, 2'b01);
      chk_pins();
      rd_block(`SBCP_IDX_OE, 8);
      // Strap moves after capture: address must not follow
      ADDRESS_SELECT_STRAP = 1'b1;
      probe(`SBCP_ADDR_STRAP0, 1'b1);
      probe(`SBCP_ADDR_STRAP1, 1'b0);
      // Random data, sweeping override bit and every software code
      for (int i = 0; i < 8; i++) begin
         lfsr = lfsr_next(lfsr);
         d1 = {lfsr[7:6], i[2:0], lfsr[2:0]};
         dq = {lfsr[15:8], d1};
         wr_block(`SBCP_IDX_OE, 8'h02, dq);
         chk_pins();
         rd_block(`SBCP_IDX_OE, 2);
      end
      // Over-count byte, reserved index and count register
      dq = {8'h00, 8'h5a};
      wr_block(`SBCP_IDX_SPREAD, 8'h01, dq);
      dq = {8'h00, 8'h00};
      wr_block(8'h03, 8'h02, dq);
      dq = {8'hf3};
      wr_block(`SBCP_IDX_COUNT, 8'h01, dq);
      rd_block(`SBCP_IDX_OE, 5);
      // Reset again mid-run with other strap levels
      do_reset(1'b1, 2'b11);
      probe(`SBCP_ADDR_STRAP1, 1'b1);
      probe(`SBCP_ADDR_STRAP0, 1'b0);
      chk_pins();
      rd_block(`SBCP_IDX_SPREAD, 1);
      do_reset(1'b0, 2'b00);
      chk_pins();
      rd_block(`SBCP_IDX_SPREAD, 1);
      end_sim();
   end

   // Hang guard; limit well above the longest expected run
   initial begin
      repeat (95000) @(posedge CLK);
      err_count++;
      end_sim();
   end
endmodule // tb_smbus_block_config_port
